// ==== hsid_axil_slave.sv ====
// axi4-lite slave front end that turns bus beats into register strobes
`include "hsid_defs.svh"
`default_nettype none
module hsid_axil_slave (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [`HSID_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [`HSID_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  hsid_reg_if.slave regs
);

  hsid_pkg::hsid_axil_t s_r;
  hsid_pkg::hsid_axil_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // address and data are caught independently, so either order works
  always_comb begin
    s_nxt = s_r;
    regs.wr_en = s_r.aw_have & s_r.w_have & ~s_r.bvalid;
    regs.wr_addr = s_r.aw_addr;
    regs.wr_data = s_r.w_data;
    regs.wr_strb = s_r.w_strb;
    regs.rd_en = s_r.ar_have & ~s_r.rvalid;
    regs.rd_addr = s_r.ar_addr;
    if (i_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = i_awaddr;
    end
    if (i_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = i_wdata;
      s_nxt.w_strb = i_wstrb;
    end
    if (regs.wr_en) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = regs.wr_hit ? `HSID_RESP_OKAY : `HSID_RESP_DECERR;
    end else if (s_r.bvalid && i_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (i_arvalid && s_r.arready) begin
      s_nxt.ar_have = 1'b1;
      s_nxt.ar_addr = i_araddr;
    end
    if (regs.rd_en) begin
      s_nxt.ar_have = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = regs.rd_hit ? regs.rd_data : 32'h0;
      s_nxt.rresp = regs.rd_hit ? `HSID_RESP_OKAY : `HSID_RESP_DECERR;
    end else if (s_r.rvalid && i_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // one access of each kind in flight keeps the readies simple
    s_nxt.awready = ~s_nxt.aw_have & ~s_nxt.bvalid;
    s_nxt.wready = ~s_nxt.w_have & ~s_nxt.bvalid;
    s_nxt.arready = ~s_nxt.ar_have & ~s_nxt.rvalid;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_awready = s_r.awready;
  assign o_wready = s_r.wready;
  assign o_bresp = s_r.bresp;
  assign o_bvalid = s_r.bvalid;
  assign o_arready = s_r.arready;
  assign o_rdata = s_r.rdata;
  assign o_rresp = s_r.rresp;
  assign o_rvalid = s_r.rvalid;

endmodule : hsid_axil_slave
`default_nettype wire

// ==== hsid_defs.svh ====
// register map, field positions and codes of the interrupt descriptor scheduler
`ifndef HSID_DEFS_SVH
`define HSID_DEFS_SVH

// register byte addresses
`define HSID_ADDR_W 8
`define HSID_A_CTRL 8'h00
`define HSID_A_ADDR 8'h04
`define HSID_A_STATE 8'h08
`define HSID_A_SCHED 8'h0c
`define HSID_A_IRQ_STS 8'h10
`define HSID_A_IRQ_MSK 8'h14

// control word
`define HSID_F_VALID 0
`define HSID_F_DIR_IN 1

// addressing word: frame select and payload base
`define HSID_F_FRAME_MSB 7
`define HSID_F_FRAME_LSB 0
`define HSID_F_FRAME_MS_LSB 3
`define HSID_F_BASE_MSB 23
`define HSID_F_BASE_LSB 8

// state word
`define HSID_F_ACTIVE 31
`define HSID_F_HALT 30
`define HSID_F_TOGGLE 25
`define HSID_F_CERR_MSB 24
`define HSID_F_CERR_LSB 23
`define HSID_F_BYTES_MSB 14
`define HSID_F_BYTES_LSB 0

// schedule word: select mask and per-microframe results
`define HSID_F_MASK_MSB 7
`define HSID_F_MASK_LSB 0
`define HSID_F_RES_MSB 31
`define HSID_F_RES_LSB 8
`define HSID_UF_N 8
`define HSID_RES_W 3

// result bits of one microframe
`define HSID_R_XERR 0
`define HSID_R_BABBLE 1
`define HSID_R_UNDERRUN 2

// interrupt status bits
`define HSID_I_DONE 0
`define HSID_I_ERR 1
`define HSID_I_HALT 2
`define HSID_I_W 3

// axi responses
`define HSID_RESP_OKAY 2'h0
`define HSID_RESP_DECERR 2'h3

`endif

// ==== hsid_ep_model.sv ====
// behavioural interrupt endpoint that answers the scheduler's transaction requests
`default_nettype none
module hsid_ep_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_req,
  input wire logic [3:0] i_delay,
  input wire logic i_xerr,
  input wire logic i_babble,
  input wire logic i_underrun,
  input wire logic [14:0] i_bytes,
  output logic o_done,
  output logic o_xerr,
  output logic o_babble,
  output logic o_underrun,
  output logic [14:0] o_bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [3:0] cnt;

  // one completion per request; o_done blocks a second answer
  always @(posedge i_clock) begin
    if (i_reset) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_req && !busy && !o_done) begin
        busy <= 1'b1;
        cnt <= i_delay;
      end else if (busy) begin
        if (cnt == 4'h0) begin
          o_done <= 1'b1;
          busy <= 1'b0;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end

  // outcome lines carry the inverse outside the done cycle, so a late sample shows up
  assign o_xerr = o_done ? i_xerr : ~i_xerr;
  assign o_babble = o_done ? i_babble : ~i_babble;
  assign o_underrun = o_done ? i_underrun : ~i_underrun;
  assign o_bytes = o_done ? i_bytes : ~i_bytes;
endmodule : hsid_ep_model
`default_nettype wire

// ==== hsid_if.sv ====
// interfaces between the scheduler core, its register slave and its evaluator
`include "hsid_defs.svh"
`default_nettype none
interface hsid_reg_if;
  logic wr_en;
  logic [`HSID_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic rd_en;
  logic [`HSID_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;
  modport slave(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_hit, rd_data, rd_hit);
  modport core(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_hit, rd_data, rd_hit);
endinterface : hsid_reg_if

interface hsid_eval_if;
  logic [`HSID_UF_N-1:0] mask;
  logic [4:0] frame_ms;
  logic [4:0] bus_ms;
  logic [2:0] uframe;
  logic dir_in;
  logic xerr;
  logic babble;
  logic underrun;
  logic hit;
  logic [`HSID_RES_W-1:0] result;
  modport core(output mask, frame_ms, bus_ms, uframe, dir_in, xerr, babble, underrun, input hit, result);
  modport eval(input mask, frame_ms, bus_ms, uframe, dir_in, xerr, babble, underrun, output hit, result);
endinterface : hsid_eval_if
`default_nettype wire

// ==== hsid_pkg.sv ====
// state types of the interrupt descriptor scheduler
`include "hsid_defs.svh"
`default_nettype none
package hsid_pkg;

  // transaction phase, one-hot
  typedef enum logic [1:0] {
    HSID_IDLE = 2'h1,
    HSID_WAIT = 2'h2
  } hsid_phase_t;

  // register slave state
  typedef struct packed {
    logic aw_have;
    logic [`HSID_ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_have;
    logic [`HSID_ADDR_W-1:0] ar_addr;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hsid_axil_t;

  // descriptor and scheduler state
  typedef struct packed {
    logic valid;
    logic dir_in;
    logic [15:0] base;
    logic [7:0] frame;
    logic active;
    logic halt;
    logic toggle;
    logic [1:0] cerr;
    logic [14:0] moved;
    logic [`HSID_UF_N-1:0] mask;
    logic [`HSID_UF_N*`HSID_RES_W-1:0] result;
    logic [`HSID_I_W-1:0] irq_sts;
    logic [`HSID_I_W-1:0] irq_msk;
    logic irq;
    hsid_phase_t phase;
    logic req;
    logic [2:0] cur_uf;
  } hsid_core_t;

endpackage : hsid_pkg
`default_nettype wire

// ==== hsid_sched.sv ====
// high-speed interrupt descriptor scheduler core
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`include "hsid_defs.svh"
`default_nettype none

// Function
// - each of the eight microframes keeps its own three-bit result, written when that microframe's transaction ends.
// - result bit 0 flags a transaction error on in and out transfers.
// - result bit 1 flags babble, on in tokens only.
// - result bit 2 flags underrun, on out tokens only.
// - a transaction goes out in microframe n only if frame bits 7 to 3 match the bus frame and select bit n is set.
// - a select mask of bits 0 and 4 polls every fourth microframe, an all-ones mask polls every microframe.
// - software seeds the data toggle and the block flips it after each good transaction.
// - software loads the two-bit error counter and the block counts it down on transaction errors and underruns.
// - the block records in a 15-bit field the bytes actually moved for the descriptor.
module hsid_sched (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [`HSID_ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [`HSID_ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire logic i_uframe_start,
  input wire logic [4:0] i_bus_frame,
  input wire logic [2:0] i_uframe,
  input wire logic i_txn_done,
  input wire logic i_txn_xerr,
  input wire logic i_txn_babble,
  input wire logic i_txn_underrun,
  input wire logic [14:0] i_txn_bytes,
  output logic o_txn_req,
  output logic o_txn_dir_in,
  output logic o_txn_toggle,
  output logic [15:0] o_txn_base,
  output logic [2:0] o_txn_uframe,
  output logic o_irq
);

  hsid_reg_if regs ();
  hsid_eval_if ev ();

  hsid_pkg::hsid_core_t s_r;
  hsid_pkg::hsid_core_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // bus front end
  hsid_axil_slave u_slave (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_awaddr(i_awaddr),
    .i_awvalid(i_awvalid),
    .o_awready(o_awready),
    .i_wdata(i_wdata),
    .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid),
    .o_wready(o_wready),
    .o_bresp(o_bresp),
    .o_bvalid(o_bvalid),
    .i_bready(i_bready),
    .i_araddr(i_araddr),
    .i_arvalid(i_arvalid),
    .o_arready(o_arready),
    .o_rdata(o_rdata),
    .o_rresp(o_rresp),
    .o_rvalid(o_rvalid),
    .i_rready(i_rready),
    .regs(regs.slave)
  );

  ////////////////////////////////////////////////////////////////////////////
  // microframe evaluator
  hsid_uframe_eval u_eval (
    .ev(ev.eval)
  );

  // only the millisecond part of the frame select takes part in the match
  assign ev.mask = s_r.mask;
  assign ev.frame_ms = s_r.frame[`HSID_F_FRAME_MSB:`HSID_F_FRAME_MS_LSB];
  assign ev.bus_ms = i_bus_frame;
  assign ev.uframe = i_uframe;
  assign ev.dir_in = s_r.dir_in;
  assign ev.xerr = i_txn_xerr;
  assign ev.babble = i_txn_babble;
  assign ev.underrun = i_txn_underrun;

  ////////////////////////////////////////////////////////////////////////////
  // expand byte strobes into a bit mask
  function automatic logic [31:0] hsid_lanes(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = 8'hff;
      end
    end
    return m;
  endfunction : hsid_lanes

  ////////////////////////////////////////////////////////////////////////////
  // read views of the descriptor words
  logic [31:0] ctrl_view;
  logic [31:0] addr_view;
  logic [31:0] state_view;
  logic [31:0] sched_view;

  always_comb begin
    ctrl_view = 32'h0;
    ctrl_view[`HSID_F_VALID] = s_r.valid;
    ctrl_view[`HSID_F_DIR_IN] = s_r.dir_in;
    addr_view = 32'h0;
    addr_view[`HSID_F_BASE_MSB:`HSID_F_BASE_LSB] = s_r.base;
    addr_view[`HSID_F_FRAME_MSB:`HSID_F_FRAME_LSB] = s_r.frame;
    state_view = 32'h0;
    state_view[`HSID_F_ACTIVE] = s_r.active;
    state_view[`HSID_F_HALT] = s_r.halt;
    state_view[`HSID_F_TOGGLE] = s_r.toggle;
    state_view[`HSID_F_CERR_MSB:`HSID_F_CERR_LSB] = s_r.cerr;
    state_view[`HSID_F_BYTES_MSB:`HSID_F_BYTES_LSB] = s_r.moved;
    sched_view = 32'h0;
    sched_view[`HSID_F_MASK_MSB:`HSID_F_MASK_LSB] = s_r.mask;
    sched_view[`HSID_F_RES_MSB:`HSID_F_RES_LSB] = s_r.result;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read decode; reads have no side effects
  always_comb begin
    regs.rd_hit = 1'b1;
    regs.rd_data = 32'h0;
    unique case (regs.rd_addr)
      `HSID_A_CTRL: begin
        regs.rd_data = ctrl_view;
      end
      `HSID_A_ADDR: begin
        regs.rd_data = addr_view;
      end
      `HSID_A_STATE: begin
        regs.rd_data = state_view;
      end
      `HSID_A_SCHED: begin
        regs.rd_data = sched_view;
      end
      `HSID_A_IRQ_STS: begin
        regs.rd_data[`HSID_I_W-1:0] = s_r.irq_sts;
      end
      `HSID_A_IRQ_MSK: begin
        regs.rd_data[`HSID_I_W-1:0] = s_r.irq_msk;
      end
      default: begin
        regs.rd_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write decode: which words a write would hit
  always_comb begin
    unique case (regs.wr_addr)
      `HSID_A_CTRL, `HSID_A_ADDR, `HSID_A_STATE, `HSID_A_SCHED, `HSID_A_IRQ_STS, `HSID_A_IRQ_MSK: begin
        regs.wr_hit = 1'b1;
      end
      default: begin
        regs.wr_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: set wins both ways; the hw select
  // clear runs before the sw set, the hw status
  // set runs after the sw clear
  logic [31:0] lanes;
  logic [31:0] wmerge;
  logic [31:0] wonly;
  logic done;
  logic bad;
  logic stop;

  always_comb begin
    s_nxt = s_r;
    lanes = hsid_lanes(regs.wr_strb);
    wmerge = 32'h0;
    wonly = regs.wr_data & lanes;
    done = (s_r.phase == hsid_pkg::HSID_WAIT) && i_txn_done;
    bad = ev.result[`HSID_R_XERR] | ev.result[`HSID_R_UNDERRUN];
    stop = 1'b0;

    // close the served microframe
    if (done) begin
      for (int k = 0; k < `HSID_UF_N; k++) begin
        if (3'(k) == s_r.cur_uf) begin
          s_nxt.result[k*`HSID_RES_W +: `HSID_RES_W] = ev.result;
          s_nxt.mask[k] = 1'b0;
        end
      end
    end

    // software writes, byte lanes honoured except at the irq mask, which an unstrobed lane 0 clears
    if (regs.wr_en) begin
      unique case (regs.wr_addr)
        `HSID_A_CTRL: begin
          wmerge = (ctrl_view & ~lanes) | wonly;
          s_nxt.valid = wmerge[`HSID_F_VALID];
          s_nxt.dir_in = wmerge[`HSID_F_DIR_IN];
        end
        `HSID_A_ADDR: begin
          wmerge = (addr_view & ~lanes) | wonly;
          s_nxt.base = wmerge[`HSID_F_BASE_MSB:`HSID_F_BASE_LSB];
          s_nxt.frame = wmerge[`HSID_F_FRAME_MSB:`HSID_F_FRAME_LSB];
        end
        `HSID_A_STATE: begin
          wmerge = (state_view & ~lanes) | wonly;
          s_nxt.active = wmerge[`HSID_F_ACTIVE];
          s_nxt.toggle = wmerge[`HSID_F_TOGGLE];
          s_nxt.cerr = wmerge[`HSID_F_CERR_MSB:`HSID_F_CERR_LSB];
          s_nxt.moved = wmerge[`HSID_F_BYTES_MSB:`HSID_F_BYTES_LSB];
          // rearming with active set releases a halted descriptor
          if (wmerge[`HSID_F_ACTIVE]) begin
            s_nxt.halt = 1'b0;
          end
        end
        `HSID_A_SCHED: begin
          // select bits only go from 0 to 1 by software
          s_nxt.mask = s_nxt.mask | wonly[`HSID_F_MASK_MSB:`HSID_F_MASK_LSB];
        end
        `HSID_A_IRQ_STS: begin
          s_nxt.irq_sts = s_r.irq_sts & ~wonly[`HSID_I_W-1:0];
        end
        `HSID_A_IRQ_MSK: begin
          s_nxt.irq_msk = wonly[`HSID_I_W-1:0];
        end
        default: begin
          wmerge = 32'h0;
        end
      endcase
    end

    // issue: halted or inactive descriptors are never scheduled
    if (s_r.phase == hsid_pkg::HSID_IDLE && i_uframe_start && s_r.valid && s_r.active && !s_r.halt && ev.hit) begin
      s_nxt.phase = hsid_pkg::HSID_WAIT;
      s_nxt.cur_uf = i_uframe;
    end

    // completion: toggle, error count, halt and byte count
    if (done) begin
      s_nxt.phase = hsid_pkg::HSID_IDLE;
      if (bad) begin
        // a zero count means unlimited retries and never halts
        if (s_r.cerr == 2'h1) begin
          s_nxt.cerr = 2'h0;
          stop = 1'b1;
        end else if (s_r.cerr != 2'h0) begin
          s_nxt.cerr = s_r.cerr - 2'h1;
        end
      end else if (ev.result[`HSID_R_BABBLE]) begin
        stop = 1'b1;
      end else begin
        s_nxt.toggle = ~s_r.toggle;
        s_nxt.moved = s_r.moved + i_txn_bytes;
      end
      if (stop) begin
        s_nxt.halt = 1'b1;
        s_nxt.active = 1'b0;
      end else if (s_nxt.mask == '0) begin
        // every selected microframe served: descriptor retires
        s_nxt.active = 1'b0;
      end
      s_nxt.irq_sts[`HSID_I_DONE] = 1'b1;
      if (ev.result != '0) begin
        s_nxt.irq_sts[`HSID_I_ERR] = 1'b1;
      end
      if (stop) begin
        s_nxt.irq_sts[`HSID_I_HALT] = 1'b1;
      end
    end

    s_nxt.req = (s_nxt.phase == hsid_pkg::HSID_WAIT);
    s_nxt.irq = |(s_nxt.irq_sts & s_nxt.irq_msk);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_r <= '{phase: hsid_pkg::HSID_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side outputs straight from the state register
  assign o_txn_req = s_r.req;
  assign o_txn_dir_in = s_r.dir_in;
  assign o_txn_toggle = s_r.toggle;
  assign o_txn_base = s_r.base;
  assign o_txn_uframe = s_r.cur_uf;
  assign o_irq = s_r.irq;

endmodule : hsid_sched
`default_nettype wire

// ==== hsid_sched_properties.sv ====
// concurrent checks on the scheduler's bus and transaction ports
`default_nettype none
module hsid_sched_properties (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic [1:0] o_bresp,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic i_rready,
  input wire logic i_uframe_start,
  input wire logic [2:0] i_uframe,
  input wire logic i_txn_done,
  input wire logic o_txn_req,
  input wire logic [2:0] o_txn_uframe,
  input wire logic o_txn_toggle,
  input wire logic o_txn_dir_in
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  ////////////////////////////////////////////////////////////////////////////////
  // transaction issue and completion
  a_issue_on_start: assert property ($rose(o_txn_req) |-> $past(i_uframe_start))
    else $error("issue without start");
  a_issue_uframe: assert property ($rose(o_txn_req) |-> o_txn_uframe == $past(i_uframe))
    else $error("wrong microframe");
  a_req_drop_done: assert property (o_txn_req && i_txn_done |=> !o_txn_req)
    else $error("request held after done");
  // qualifiers must not move under the far side while it works
  a_req_hold_stable: assert property (o_txn_req && !i_txn_done |=>
      o_txn_req && $stable(o_txn_uframe) && $stable(o_txn_toggle) && $stable(o_txn_dir_in))
    else $error("qualifiers moved");

  ////////////////////////////////////////////////////////////////////////////////
  // register bus answers
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  a_read_answer: assert property (i_arvalid && o_arready |-> ##2 o_rvalid)
    else $error("read response late");
  a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response not held");
  a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read response not held");
  a_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write beat accepted during response");

  c_issue: cover property ($rose(o_txn_req));
  c_done: cover property (o_txn_req && i_txn_done);
  c_write: cover property (o_bvalid && i_bready);
endmodule : hsid_sched_properties

bind hsid_sched hsid_sched_properties u_props (.*);
`default_nettype wire

// ==== hsid_tb.sv ====
// self-checking bench for the interrupt descriptor scheduler
`include "hsid_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_uframe_start;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, d;
  logic [3:0] i_wstrb, delay;
  logic [4:0] i_bus_frame;
  logic [2:0] i_uframe, o_txn_uframe;
  logic [1:0] o_bresp, o_rresp, r;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_txn_req, o_txn_dir_in, o_txn_toggle, o_irq;
  logic [15:0] o_txn_base;
  logic done, xerr, bab, und, exp_dir, exp_tog, req_q;
  logic [14:0] bytes;
  logic [7:0] xerr_at, bab_at, und_at, seen;
  int n_mismatch, checks_done;

  hsid_sched dut (.*, .i_txn_done(done), .i_txn_xerr(xerr), .i_txn_babble(bab), .i_txn_underrun(und),
    .i_txn_bytes(bytes));

  hsid_ep_model ep (.i_clock(i_clock), .i_reset(i_reset), .i_req(o_txn_req), .i_delay(delay),
    .i_xerr(xerr_at[o_txn_uframe]), .i_babble(bab_at[o_txn_uframe]), .i_underrun(und_at[o_txn_uframe]),
    .i_bytes(15'h0040), .o_done(done), .o_xerr(xerr), .o_babble(bab), .o_underrun(und), .o_bytes(bytes));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    n_mismatch++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic got = 1'b0;
    @(posedge i_clock);
    i_awaddr <= a;
    i_awvalid <= 1'b1;
    i_wdata <= v;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!got) begin
      @(posedge i_clock);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) begin
        resp = o_bresp;
        got = 1'b1;
      end
    end
    i_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic got = 1'b0;
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    while (!got) begin
      @(posedge i_clock);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) begin
        v = o_rdata;
        resp = o_rresp;
        got = 1'b1;
      end
    end
    i_rready <= 1'b0;
  endtask : axi_read

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, d, r);
    chk(d, exp);
  endtask : rd_chk

  // software seeds the descriptor
  task automatic setup(input logic dir, input logic [7:0] frm, input logic [7:0] msk, input logic tog,
                       input logic [1:0] ce);
    exp_dir = dir;
    exp_tog = tog;
    axi_write(`HSID_A_IRQ_STS, 32'h0000_0007, r);
    axi_write(`HSID_A_CTRL, {30'h0, dir, 1'b1}, r);
    axi_write(`HSID_A_ADDR, {8'h00, 16'h1234, frm}, r);
    axi_write(`HSID_A_STATE, {1'b1, 5'h00, tog, ce, 23'h0}, r);
    axi_write(`HSID_A_SCHED, {24'h0, msk}, r);
    axi_write(`HSID_A_IRQ_MSK, 32'h0000_0007, r);
  endtask : setup

  // one millisecond of microframe starts
  task automatic run_frame(input logic [4:0] f);
    seen = 8'h00;
    for (int n = 0; n < 8; n++) begin
      @(posedge i_clock);
      i_uframe_start <= 1'b1;
      i_bus_frame <= f;
      i_uframe <= n[2:0];
      @(posedge i_clock);
      i_uframe_start <= 1'b0;
      repeat (3) @(posedge i_clock);
      while (o_txn_req) @(posedge i_clock);
    end
    repeat (2) @(posedge i_clock);
  endtask : run_frame

  // checks every issue; toggle flips only on a clean transaction
  always @(posedge i_clock) begin
    req_q <= o_txn_req;
    if (o_txn_req && !req_q) begin
      seen[o_txn_uframe] = 1'b1;
      chk(32'(o_txn_base), 32'h0000_1234);
      chk(32'(o_txn_dir_in), 32'(exp_dir));
      chk(32'(o_txn_toggle), 32'(exp_tog));
    end
    if (done && !xerr && !(exp_dir ? bab : und)) exp_tog = ~exp_tog;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_uframe_start} = 6'h00;
    {i_awaddr, i_araddr, i_wdata, i_bus_frame, i_uframe} = 56'h0;
    i_wstrb = 4'hf;
    {delay, xerr_at, bab_at, und_at} = 28'h0;
    i_reset = 1'b1;
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clock);
    for (int a = 0; a <= 20; a += 4) begin
      rd_chk(a[7:0], 32'h0);
    end
    axi_write(8'h20, 32'hffff_ffff, r);
    chk(32'(r), 32'(`HSID_RESP_DECERR));
    axi_read(8'h20, d, r);
    chk(32'(r), 32'(`HSID_RESP_DECERR));
    chk(d, 32'h0);
    // every fourth microframe, clean in transfers, prompt endpoint
    setup(1'b1, 8'h00, 8'h11, 1'b0, 2'h3);
    rd_chk(`HSID_A_ADDR, 32'h0012_3400);
    run_frame(5'h00);
    chk(32'(seen), 32'h0000_0011);
    rd_chk(`HSID_A_SCHED, 32'h0000_0000);
    rd_chk(`HSID_A_STATE, 32'h0180_0080);
    rd_chk(`HSID_A_IRQ_STS, 32'h0000_0001);
    chk(32'(o_irq), 32'h1);
    axi_write(`HSID_A_IRQ_MSK, 32'h0, r);
    repeat (2) @(posedge i_clock);
    chk(32'(o_irq), 32'h0);
    axi_write(`HSID_A_IRQ_STS, 32'h0000_0001, r);
    rd_chk(`HSID_A_IRQ_STS, 32'h0);
    // out, frame select 1, all microframes, slow faulty endpoint
    delay = 4'h5;
    und_at = 8'h04;
    bab_at = 8'h20;
    xerr_at = 8'h40;
    setup(1'b0, 8'h08, 8'hff, 1'b1, 2'h0);
    run_frame(5'h00);
    chk(32'(seen), 32'h0);
    run_frame(5'h01);
    chk(32'(seen), 32'h0000_00ff);
    rd_chk(`HSID_A_SCHED, 32'h0401_0000);
    rd_chk(`HSID_A_STATE, 32'h0200_0180);
    rd_chk(`HSID_A_IRQ_STS, 32'h0000_0003);
    // in transfers, error count runs out and halts
    delay = 4'h1;
    {und_at, bab_at} = 16'h0;
    xerr_at = 8'h03;
    setup(1'b1, 8'h00, 8'hff, 1'b1, 2'h2);
    run_frame(5'h00);
    chk(32'(seen), 32'h0000_0003);
    rd_chk(`HSID_A_SCHED, 32'h0401_09fc);
    rd_chk(`HSID_A_STATE, 32'h4200_0000);
    axi_read(`HSID_A_IRQ_STS, d, r);
    chk(d & 32'h4, 32'h4);
    axi_write(`HSID_A_SCHED, 32'h0, r);
    rd_chk(`HSID_A_SCHED, 32'h0401_09fc);
    // restart, babble on an in token halts at once
    xerr_at = 8'h00;
    bab_at = 8'h04;
    axi_write(`HSID_A_STATE, {1'b1, 5'h00, 1'b1, 2'h3, 23'h0}, r);
    run_frame(5'h00);
    chk(32'(seen), 32'h0000_0004);
    rd_chk(`HSID_A_SCHED, 32'h0400_89f8);
    rd_chk(`HSID_A_STATE, 32'h4380_0000);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire

// ==== hsid_uframe_eval.sv ====
// microframe match and result encoding for the interrupt descriptor scheduler
`include "hsid_defs.svh"
`default_nettype none
module hsid_uframe_eval (
  hsid_eval_if.eval ev
);

  ////////////////////////////////////////////////////////////////////////////
  // issue only in the selected microframe of a matching millisecond frame
  assign ev.hit = (ev.frame_ms == ev.bus_ms) && ev.mask[ev.uframe];

  ////////////////////////////////////////////////////////////////////////////
  // babble only counts on in tokens, underrun only on out tokens
  assign ev.result[`HSID_R_XERR] = ev.xerr;
  assign ev.result[`HSID_R_BABBLE] = ev.babble & ev.dir_in;
  assign ev.result[`HSID_R_UNDERRUN] = ev.underrun & ~ev.dir_in;

endmodule : hsid_uframe_eval
`default_nettype wire
